/* design/uaf_address_filter.sv */
// Summary of operation
// - Filter only in modes 1, 2, 3 with enable
// - Address frames flag only on address match
// - Enable cleared: every data frame flags
// - Mode 1: stop bit replaces ninth bit
// - Mode 0 ignores the filter enable
// - Given address: mask zero is don't-care
// - Broadcast is address OR mask, ones match
// - Reset zeros address and mask: all match
// - Compare runs while processor idles
// - Example address and mask select expected bytes
// - Two-bit field selects four modes
// - Start bit starts frame only when enabled
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module uaf_address_filter
  import uaf_pkg::*;
(
  input  wire logic        clock,        // 200 MHz system clock
  input  wire logic        rstn,         // Synchronous reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  output logic             irq,          // Level interrupt
  output logic             shiftClkOut,  // Mode 0 shift clock
  input  wire logic        rxdPin        // Serial receive pin
);

  // ---------------------------------------------------------------
  // State of the module
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  sync;
    logic        rxLvl;
    logic [1:0]  mode;
    logic        filtEn;
    logic        rxEn;
    logic [7:0]  nodeAddr;
    logic [7:0]  nodeMask;
    logic [15:0] baudDiv;
    logic [15:0] baudCnt;
    logic [3:0]  bitCnt;
    logic [7:0]  shByte;
    logic        ninth;
    logic [7:0]  rxData;
    logic        rxNinth;
    logic [2:0]  irqSts;
    logic [2:0]  irqMsk;
    uaf_rxst_t   st;
    logic        shiftClk;
    logic        ack;
    logic [31:0] rdData;
    logic        err;
  } uaf_state_t;

  uaf_state_t s_q;
  uaf_state_t s_d;

  logic       givenHit;
  logic       bcastHit;
  logic       addrHit;
  logic       lvlNew;
  logic       fallEdge;
  logic       cntZero;
  logic       filtOn;
  logic       stopOk;
  logic       ninthEff;
  logic       accept;
  logic       access;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Known register offset
  function automatic logic regValid(input logic [7:0] a);
    regValid = (a == OFS_CTRL)   || (a == OFS_RXDATA) ||
               (a == OFS_NADDR)  || (a == OFS_NMASK)  ||
               (a == OFS_BAUD)   || (a == OFS_IRQSTS) ||
               (a == OFS_IRQMSK);
  endfunction

  // Half of the bit period, at least one cycle
  function automatic logic [15:0] halfDiv(input logic [15:0] d);
    halfDiv = (d > 16'h0001) ? {1'b0, d[15:1]} : 16'h0001;
  endfunction

  // ---------------------------------------------------------------
  // Address comparator, always active
  // ---------------------------------------------------------------
  // Runs from the shift register whatever the processor does
  uaf_addr_match u_match (
    .rxByte   (s_q.shByte),
    .nodeAddr (s_q.nodeAddr),
    .nodeMask (s_q.nodeMask),
    .givenHit (givenHit),
    .bcastHit (bcastHit),
    .addrHit  (addrHit)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    access   = psel & penable;
    stopOk   = 1'b0;
    ninthEff = 1'b0;
    accept   = 1'b0;

    // Pin synchroniser, level counts once stages two and three agree
    s_d.sync = {s_q.sync[1:0], rxdPin};
    lvlNew   = (s_q.sync[1] == s_q.sync[2]) ? s_q.sync[2] : s_q.rxLvl;
    s_d.rxLvl = lvlNew;
    fallEdge = s_q.rxLvl & ~lvlNew;
    cntZero  = (s_q.baudCnt == 16'h0000);

    // Filtering needs the enable and an asynchronous mode
    filtOn = s_q.filtEn && (s_q.mode != MODE_SYNC);

    // APB: capture read data, then answer and commit write
    if (access && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.err = ~regValid(paddr);
      case (paddr)
        OFS_CTRL: begin
          s_d.rdData = {24'h000000, s_q.mode, s_q.filtEn, s_q.rxEn,
                        1'b0, s_q.rxNinth, 1'b0, s_q.irqSts[EV_RXDONE]};
        end
        OFS_RXDATA: s_d.rdData = {24'h000000, s_q.rxData};
        OFS_NADDR:  s_d.rdData = {24'h000000, s_q.nodeAddr};
        OFS_NMASK:  s_d.rdData = {24'h000000, s_q.nodeMask};
        OFS_BAUD:   s_d.rdData = {16'h0000, s_q.baudDiv};
        OFS_IRQSTS: s_d.rdData = {29'h00000000, s_q.irqSts};
        OFS_IRQMSK: s_d.rdData = {29'h00000000, s_q.irqMsk};
        default:    s_d.rdData = 32'h00000000;
      endcase
    end else if (access && s_q.ack) begin
      s_d.ack = 1'b0;
      if (pwrite) begin
        case (paddr)
          OFS_CTRL: begin
            // Two-bit mode field
            s_d.mode   = {pwdata[CTRL_MODE_HI],
                          pwdata[CTRL_MODE_LO]};
            s_d.filtEn = pwdata[CTRL_FILTEN];
            s_d.rxEn   = pwdata[CTRL_RXEN];
          end
          OFS_NADDR:  s_d.nodeAddr = pwdata[7:0];
          OFS_NMASK:  s_d.nodeMask = pwdata[7:0];
          OFS_BAUD:   s_d.baudDiv  = pwdata[15:0];
          OFS_IRQSTS: s_d.irqSts   = s_q.irqSts & ~pwdata[2:0];
          OFS_IRQMSK: s_d.irqMsk   = pwdata[2:0];
          default: begin
          end
        endcase
      end
    end else begin
      s_d.ack = 1'b0;
    end

    // Receiver; its event sets come after clears so sets win
    case (s_q.st)
      ST_IDLE: begin
        s_d.shiftClk = 1'b1;
        if (s_q.rxEn && s_q.mode == MODE_SYNC &&
            !s_q.irqSts[EV_RXDONE]) begin
          s_d.st      = ST_SYNC;
          s_d.bitCnt  = 4'h0;
          s_d.baudCnt = halfDiv(s_q.baudDiv);
        end else if (s_q.rxEn && s_q.mode != MODE_SYNC &&
                     fallEdge) begin
          // Start bit only starts a frame while enabled
          s_d.st      = ST_START;
          s_d.baudCnt = halfDiv(s_q.baudDiv);
        end
      end
      ST_START: begin
        if (cntZero) begin
          s_d.baudCnt = s_q.baudDiv;
          s_d.bitCnt  = 4'h0;
          s_d.st      = s_q.rxLvl ? ST_IDLE : ST_DATA;
        end else begin
          s_d.baudCnt = s_q.baudCnt - 16'h0001;
        end
      end
      ST_DATA: begin
        if (cntZero) begin
          s_d.baudCnt = s_q.baudDiv;
          s_d.shByte  = {s_q.rxLvl, s_q.shByte[7:1]};
          s_d.bitCnt  = s_q.bitCnt + 4'h1;
          if (s_q.bitCnt == DATA_BITS - 4'h1) begin
            // Modes 2 and 3 carry a ninth bit
            s_d.st = (s_q.mode == MODE_8BIT) ? ST_STOP : ST_NINTH;
          end
        end else begin
          s_d.baudCnt = s_q.baudCnt - 16'h0001;
        end
      end
      ST_NINTH: begin
        if (cntZero) begin
          s_d.baudCnt = s_q.baudDiv;
          s_d.ninth   = s_q.rxLvl;
          s_d.st      = ST_STOP;
        end else begin
          s_d.baudCnt = s_q.baudCnt - 16'h0001;
        end
      end
      ST_STOP: begin
        if (cntZero) begin
          stopOk = s_q.rxLvl;
          // Mode 1 uses the stop bit as the ninth bit
          ninthEff = (s_q.mode == MODE_8BIT) ? stopOk : s_q.ninth;
          // Byte compared in the same cycle the frame ends
          if (!filtOn) begin
            accept = 1'b1;
          end else if (s_q.mode == MODE_8BIT) begin
            accept = stopOk && addrHit;
          end else begin
            // Only address frames that match are flagged
            accept = s_q.ninth && addrHit;
          end
          if (accept) begin
            s_d.rxData            = s_q.shByte;
            s_d.rxNinth           = ninthEff;
            s_d.irqSts[EV_RXDONE] = 1'b1;
            s_d.irqSts[EV_ADDR]   = s_d.irqSts[EV_ADDR] | filtOn;
          end
          if (!stopOk) begin
            s_d.irqSts[EV_FRAME] = 1'b1;
          end
          s_d.st = ST_IDLE;
        end else begin
          s_d.baudCnt = s_q.baudCnt - 16'h0001;
        end
      end
      ST_SYNC: begin
        // Shift mode never filters, enable bit unused here
        if (cntZero) begin
          s_d.baudCnt = halfDiv(s_q.baudDiv);
          if (s_q.shiftClk) begin
            if (s_q.bitCnt == DATA_BITS) begin
              s_d.rxData            = s_q.shByte;
              s_d.irqSts[EV_RXDONE] = 1'b1;
              s_d.st                = ST_IDLE;
            end else begin
              s_d.shiftClk = 1'b0;
            end
          end else begin
            s_d.shiftClk = 1'b1;
            s_d.shByte   = {s_q.rxLvl, s_q.shByte[7:1]};
            s_d.bitCnt   = s_q.bitCnt + 4'h1;
          end
        end else begin
          s_d.baudCnt = s_q.baudCnt - 16'h0001;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q          <= '0;
      s_q.sync     <= 3'b111;
      s_q.rxLvl    <= 1'b1;
      // Zero address and mask make every frame match
      s_q.nodeAddr <= NADDR_RST;
      s_q.nodeMask <= NMASK_RST;
      s_q.baudDiv  <= BAUD_DIV_RST;
      s_q.st       <= ST_IDLE;
      s_q.shiftClk <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata      = s_q.rdData;
  assign pready      = s_q.ack;
  assign pslverr     = s_q.ack & s_q.err;
  // High while any sticky event with its enable bit set is pending
  assign irq         = |(s_q.irqSts & s_q.irqMsk);
  assign shiftClkOut = s_q.shiftClk;

endmodule
`default_nettype wire

/* pkg/uaf_pkg.sv */
`default_nettype none
package uaf_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // serial_control_reg
  localparam logic [7:0] OFS_RXDATA = 8'h04; // Received byte
  localparam logic [7:0] OFS_NADDR  = 8'h08; // node_address
  localparam logic [7:0] OFS_NMASK  = 8'h0C; // node_address_mask
  localparam logic [7:0] OFS_BAUD   = 8'h10; // Bit period in clocks, minus one
  localparam logic [7:0] OFS_IRQSTS = 8'h14; // Sticky events, W1C
  localparam logic [7:0] OFS_IRQMSK = 8'h18; // Event enables

  // ---------------------------------------------------------------
  // Field positions in serial_control_reg
  // ---------------------------------------------------------------
  localparam int CTRL_RXDONE  = 0; // rx_done_flag, read only
  localparam int CTRL_NINTH   = 2; // Ninth bit of last frame, read only
  localparam int CTRL_RXEN    = 4; // Receive enable
  localparam int CTRL_FILTEN  = 5; // multiproc_filter_enable
  localparam int CTRL_MODE_LO = 6; // serial_mode_bit_lo
  localparam int CTRL_MODE_HI = 7; // serial_mode_bit_hi

  // ---------------------------------------------------------------
  // Field positions in the interrupt registers
  // ---------------------------------------------------------------
  localparam int EV_RXDONE = 0; // Frame accepted
  localparam int EV_FRAME  = 1; // Missing stop bit
  localparam int EV_ADDR   = 2; // auto_address_match hit

  // ---------------------------------------------------------------
  // Reset values and mode codes
  // ---------------------------------------------------------------
  localparam logic [15:0] BAUD_DIV_RST  = 16'h006C;
  localparam logic [7:0]  NADDR_RST     = 8'h00;
  localparam logic [7:0]  NMASK_RST     = 8'h00;
  localparam logic [1:0]  MODE_SYNC     = 2'h0;
  localparam logic [1:0]  MODE_8BIT     = 2'h1;
  localparam logic [3:0]  DATA_BITS     = 4'h8;

  // Receiver states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_DATA  = 6'b000100,
    ST_NINTH = 6'b001000,
    ST_STOP  = 6'b010000,
    ST_SYNC  = 6'b100000
  } uaf_rxst_t;

endpackage
`default_nettype wire

/* design/uaf_addr_match.sv */
`timescale 1ns/10ps
`default_nettype none
module uaf_addr_match (
  input  wire logic [7:0] rxByte,      // Received address byte
  input  wire logic [7:0] nodeAddr,    // node_address
  input  wire logic [7:0] nodeMask,    // node_address_mask
  output logic            givenHit,    // Matches given address
  output logic            bcastHit,    // Matches broadcast address
  output logic            addrHit      // Either pattern matches
);

  // ---------------------------------------------------------------
  // Pattern compare
  // ---------------------------------------------------------------
  logic [7:0] bcastPat;

  // Mask zero bits are don't-care, one bits must equal the address
  assign givenHit = ((rxByte ^ nodeAddr) & nodeMask) == 8'h00;
  // Broadcast pattern: ones must match, zeros are don't-care
  assign bcastPat = nodeAddr | nodeMask;
  assign bcastHit = (rxByte & bcastPat) == bcastPat;
  // All-zero address and mask leave both fully don't-care
  assign addrHit  = givenHit | bcastHit;

endmodule
`default_nettype wire

/* testbench/uaf_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module uaf_sva
  import uaf_pkg::*;
(
  input wire logic        clock,       // Clock
  input wire logic        rstn,        // Reset
  input wire logic        psel,        // Select
  input wire logic        penable,     // Access
  input wire logic        pwrite,      // Write
  input wire logic [7:0]  paddr,       // Address
  input wire logic [31:0] pwdata,      // Write data
  input wire logic [31:0] prdata,      // Read data
  input wire logic        pready,      // Ready
  input wire logic        pslverr,     // Error
  input wire logic        irq,         // Interrupt
  input wire logic        shiftClkOut, // Shift clock
  input wire logic        rxdPin       // Serial in
);
  // --------------------------------
  // Port timing checks
  // --------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_IN_ACCESS: assert property (pready |->
    psel && penable && $past(psel && penable)) else $error("stray ready");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_MAPPED: assert property (pready && paddr <= OFS_IRQMSK
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
  AST_UNMAPPED: assert property (pready && paddr > OFS_IRQMSK
    |-> pslverr && prdata == 32'h0) else $error("unmapped accepted");
  AST_IRQ_FALL: assert property ($fell(irq) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("interrupt dropped alone");
  AST_RESET: assert property (disable iff (1'b0) !rstn |=>
    !pready && !pslverr && !irq && shiftClkOut) else $error("reset state");
  AST_SCLK_LOW: assert property ($fell(shiftClkOut) |=> !shiftClkOut)
    else $error("shift clock glitch");
  // Main scenarios
  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($fell(shiftClkOut));
endmodule
bind uaf_address_filter uaf_sva i_sva (.clock(clock), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .shiftClkOut(shiftClkOut), .rxdPin(rxdPin));
`default_nettype wire

/* testbench/uaf_line_master.sv */
`timescale 1ns/10ps
`default_nettype none
module uaf_line_master (
  input  wire logic clock, // System clock
  input  wire logic sclk,  // Mode 0 shift clock
  output var logic  rxd    // Serial line, idle high
);
  int bitLen = 16; // Clocks per bit
  initial rxd = 1'b1;
  // Asynchronous frame, LSB first
  task automatic send(input logic [7:0] b, input logic nine,
                      input logic nin, input logic stp);
    logic [10:0] f;
    f = {stp, nin, b, 1'b0};
    if (!nine) f[9] = stp;
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxd <= f[i];
      repeat (bitLen) @(posedge clock);
    end
    rxd <= 1'b1;
  endtask
  // Mode 0 data changes after each shift clock fall
  task automatic shift(input logic [7:0] b, output logic ok);
    logic prev;
    int t;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      t = 0;
      do begin
        prev = sclk;
        @(posedge clock);
        t++;
      end while (!(prev && !sclk) && t < 300);
      if (t >= 300) ok = 1'b0;
      rxd <= b[i];
    end
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import uaf_pkg::*;
  logic        clock, rstn, psel, penable, pwrite, pready, pslverr;
  logic        irq, sclk, rxd, err, ok;
  logic [7:0]  paddr, na, nm, b;
  logic [31:0] pwdata, prdata, rd, msk;
  logic [13:0] dir [10] = '{{2'd2, 4'hF, 8'hF0}, {2'd2, 4'hF, 8'hF1},
    {2'd3, 4'hF, 8'h71}, {2'd3, 4'hF, 8'hFB}, {2'd3, 4'hB, 8'hF0},
    {2'd3, 4'h3, 8'h33}, {2'd1, 4'hF, 8'hF1}, {2'd1, 4'hD, 8'hF1},
    {2'd1, 4'h5, 8'h55}, {2'd2, 4'hE, 8'hF1}};
  int miscompares = 0, checksDone = 0, seed = 91554, md, st;
  uaf_address_filter i_dut (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .shiftClkOut(sclk), .rxdPin(rxd));
  uaf_line_master i_master (.clock(clock), .sclk(sclk), .rxd(rxd));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer, read data into rd
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done;
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Reference acceptance model
  function automatic int accept(int m, f, n9, s, en, logic [7:0] x);
    if (!en) return 0;
    if (!f) return 1;
    if ((((x ^ na) & nm) != 0) && ((x & (na | nm)) != (na | nm))) return 0;
    return m == 1 ? s : n9;
  endfunction
  task automatic frame(int m, f, n9, s, en, logic [7:0] x);
    int a, e, c;
    a = accept(m, f, n9, s, en, x);
    e = (a << EV_RXDONE) | ((en && !s) << EV_FRAME) | ((f && a) << EV_ADDR);
    // Control readback; mode 1 reports the stop bit as ninth bit
    c = (m << CTRL_MODE_LO) | (f << CTRL_FILTEN) | (en << CTRL_RXEN) |
        ((m == 1 ? s : n9) << CTRL_NINTH) | (a << CTRL_RXDONE);
    apb(1, OFS_CTRL, (m << CTRL_MODE_LO) | (f << CTRL_FILTEN) |
        (en << CTRL_RXEN));
    i_master.send(x, m != 1, n9, s);
    repeat (8) @(posedge clock);
    apb(0, OFS_IRQSTS, 0);
    check("status", rd, e);
    check("irq", irq, (e & msk) != 0);
    if (a) apb(0, OFS_CTRL, 0);
    if (a) check("control", rd, c);
    if (a) apb(0, OFS_RXDATA, 0);
    if (a) check("rx byte", rd, x);
    apb(1, OFS_IRQSTS, 7);
    // Clear lands at the completing edge; look one cycle later
    @(posedge clock);
    check("irq clear", irq, 0);
  endtask
  initial begin
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(0, 8'(4 * i), 0);
      check("reset value", rd, i == 4 ? BAUD_DIV_RST : 0);
      check("error flag", err, i == 7);
    end
    apb(1, 8'h20, 0);
    check("unmapped write", err, 1);
    $display("reset values test done");
    apb(1, OFS_BAUD, 15); // Bit period is the divider plus one
    msk = 0; na = NADDR_RST; nm = NMASK_RST;
    frame(2, 1, 1, 1, 1, 8'h5A);
    msk = 7;
    apb(1, OFS_IRQMSK, msk);
    frame(3, 1, 1, 1, 1, 8'hA5);
    na = 8'hF1; nm = 8'hFA;
    apb(1, OFS_NADDR, na);
    apb(1, OFS_NMASK, nm);
    foreach (dir[i]) frame(dir[i][13:12], dir[i][11], dir[i][10],
                           dir[i][9], dir[i][8], dir[i][7:0]);
    $display("directed frames test done");
    for (int i = 0; i < 8; i++) begin
      md = 1 + ($unsigned($random(seed)) % 3);
      st = md == 1 ? $random(seed) & 1 : 1;
      b = $random(seed);
      if (i[0]) b[7:3] = 5'b11110;
      frame(md, $random(seed) & 1, $random(seed) & 1, st, 1, b);
    end
    $display("random frames test done");
    fork
      i_master.shift(8'h3C, ok);
      apb(1, OFS_CTRL, (1 << CTRL_FILTEN) | (1 << CTRL_RXEN));
    join
    check("shift done", ok, 1);
    // Last shift edge plus the closing high phase
    repeat (24) @(posedge clock);
    apb(0, OFS_IRQSTS, 0);
    check("mode 0 status", rd, 1 << EV_RXDONE);
    apb(0, OFS_RXDATA, 0);
    check("mode 0 byte", rd, 8'h3C);
    apb(1, OFS_CTRL, 0);
    $display("mode 0 test done");
    test_done;
  end
endmodule
`default_nettype wire
